// ==== pic_cpu_model.sv ====
// CPU and transfer controller model that acknowledges requests
module pic_cpu_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Cycles waited before each acknowledge
    input wire logic [3:0] lag,
    // CPU side
    input wire logic cpu_req,
    input wire logic [15:0] cpu_vec_addr,
    output logic cpu_ack,
    output logic [7:0] cpu_cnt,
    output logic [15:0] cpu_last,
    // Transfer controller side
    input wire logic dtc_req,
    input wire logic [7:0] dtc_vec_num,
    output logic dtc_ack,
    output logic [7:0] dtc_cnt,
    output logic [7:0] dtc_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cw_ff;
    logic [3:0] dw_ff;
    // Skip the cycle after an ack: the request still shows the old winner
    always_ff @(posedge aclk) begin
        cpu_ack <= 1'b0;
        if (!aresetn) begin
            cpu_cnt <= 8'h00;
            cw_ff <= 4'h0;
        end else if (cpu_req && !cpu_ack) begin
            cw_ff <= (cw_ff >= lag) ? 4'h0 : cw_ff + 4'h1;
            if (cw_ff >= lag) begin
                cpu_ack <= 1'b1;
                cpu_last <= cpu_vec_addr;
                cpu_cnt <= cpu_cnt + 8'h01;
            end
        end
    end
    always_ff @(posedge aclk) begin
        dtc_ack <= 1'b0;
        if (!aresetn) begin
            dtc_cnt <= 8'h00;
            dw_ff <= 4'h0;
        end else if (dtc_req && !dtc_ack) begin
            dw_ff <= (dw_ff >= lag) ? 4'h0 : dw_ff + 4'h1;
            if (dw_ff >= lag) begin
                dtc_ack <= 1'b1;
                dtc_last <= dtc_vec_num;
                dtc_cnt <= dtc_cnt + 8'h01;
            end
        end
    end
endmodule

// ==== pic_ctrl.sv ====
// Priority interrupt controller top with AXI4-Lite register slave
// Overview of operation
// RQ1: Mode field 00 gates by single mask bit
// RQ2: Mode field 10 uses mask level and priorities
// RQ3: Software sets one of four levels per module
// RQ4: Nonmaskable and flash requests always accepted, top
// RQ5: Each source gets its own vector address
// RQ6: Nonmaskable edge select: 0 falling, 1 rising
// RQ7: Each external input: falling, rising or both
// RQ8: Requests may start data transfer controller instead
// RQ9: Control bit 2 picks trigger B edge
// RQ10: Control bit 1 picks trigger A edge
// RQ11: Unused control bits read zero, written zero
// RQ12: Nine priority registers, fields reset to ones
// RQ13: Field value is the level, 00 lowest
// RQ14: Mode 2 forwards only levels above mask
//
// Added by the designer: register access over AXI4-Lite.
module pic_ctrl
    import pic_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // External and internal request inputs
    input wire logic nmi_in,
    input wire logic [NUM_EXT-1:0] ext_maskable_inputs,
    input wire logic flash_req,
    input wire logic [NUM_PERIPH-1:0] periph_req,
    // Converter trigger inputs
    input wire logic conv_trigger_a_input,
    input wire logic conv_trigger_b_input,
    // CPU mask state
    input wire logic cpu_mask_bit,
    input wire logic cpu_mask_level_hi,
    input wire logic cpu_mask_level_lo,
    // CPU request and acknowledge
    output logic cpu_req,
    output logic [15:0] cpu_vec_addr,
    input wire logic cpu_ack,
    // Data transfer controller request and acknowledge
    output logic dtc_req,
    output logic [7:0] dtc_vec_num,
    input wire logic dtc_ack,
    // Converter start strobes and summary interrupt
    output logic conv_start_a,
    output logic conv_start_b,
    output logic irq_out
);

    logic awready_ff, wready_ff, aw_held_ff, w_held_ff, bvalid_ff;
    logic arready_ff, rvalid_ff;
    logic [29:0] awidx_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] intctl_ff;
    logic [7:0] prio_ff [NUM_PRIO];
    logic [15:0] sense_ff;
    logic [7:0] dtc_en_ff;
    logic [NUM_EVT-1:0] status_ff, mask_ff;
    logic irq_out_ff;
    logic nmi_pend_ff;
    logic [NUM_EXT-1:0] irq_pend_ff;
    logic cpu_req_ff, dtc_req_ff;
    logic [7:0] cpu_vec_ff, dtc_vec_ff;
    logic [NUM_EXT:0] cpu_clr_ff, dtc_clr_ff;
    logic conv_start_a_ff, conv_start_b_ff;

    logic wr_fire;
    pic_reg_t wr_reg, rd_reg;
    logic [3:0] wr_slot, rd_slot;
    logic [31:0] wr_val, rd_val;
    logic nmi_pulse, trig_a_pulse, trig_b_pulse;
    logic [NUM_EXT-1:0] irq_pulse;
    logic [NUM_EVT-1:0] evt;
    logic [NUM_EXT:0] ack_clr;
    logic [NUM_EXT-1:0] irq_live;
    logic [NUM_SRC-1:0] cpu_pend;
    logic [1:0] src_lvl [NUM_SRC];
    logic [1:0] mask_lvl;
    logic mode2;
    logic best_valid;
    logic [1:0] best_lvl;
    logic [5:0] best_src;
    logic dtc_valid;
    logic [2:0] dtc_src;

    // Byte strobes merge new data over the old word
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) res[8*b +: 8] = new_v[8*b +: 8];
        end
        return res;
    endfunction

    // ---------------- Bus slave ----------------
    assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign wr_reg = pic_decode(awidx_ff);
    assign wr_slot = 4'(awidx_ff - IDX_PRIO_A);
    assign rd_reg = pic_decode(araddr[31:2]);
    assign rd_slot = 4'(araddr[31:2] - IDX_PRIO_A);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            awidx_ff <= '0;
        end else if (awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            awidx_ff <= awaddr[31:2];
        end else if (wr_fire) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
        end else if (wr_fire) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Reserved bits always read as zero
    always_comb begin
        rd_val = '0;
        unique case (rd_reg)
            REG_INTCTL: rd_val[7:0] = intctl_ff & INTCTL_RW_MASK; // [RQ11]
            REG_PRIO: rd_val[7:0] = prio_ff[rd_slot];
            REG_SENSE: rd_val[15:0] = sense_ff;
            REG_DTC: rd_val[7:0] = dtc_en_ff;
            REG_STATUS: rd_val[NUM_EVT-1:0] = status_ff;
            REG_MASK: rd_val[NUM_EVT-1:0] = mask_ff;
            REG_NONE: rd_val = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= (rd_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_ff && rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    // ---------------- Registers ----------------
    assign wr_val = merge(32'h0, wdata_ff, wstrb_ff);

    // Prohibited mode codes are stored but behave as mode 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            intctl_ff <= INTCTL_RST;
        end else if (wr_fire && wr_reg == REG_INTCTL && wstrb_ff[0]) begin
            intctl_ff <= wdata_ff[7:0] & INTCTL_RW_MASK; // [RQ11] [RQ1]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int r = 0; r < NUM_PRIO; r++) prio_ff[r] <= PRIO_RST; // [RQ12]
        end else if (wr_fire && wr_reg == REG_PRIO && wstrb_ff[0]) begin
            prio_ff[wr_slot] <= wdata_ff[7:0]; // [RQ3] [RQ12]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_ff <= SENSE_RST;
            dtc_en_ff <= DTC_EN_RST;
            mask_ff <= EVT_RST;
        end else if (wr_fire) begin
            if (wr_reg == REG_SENSE) sense_ff <= 16'(merge(32'(sense_ff),
                                                    wdata_ff, wstrb_ff));
            if (wr_reg == REG_DTC && wstrb_ff[0]) dtc_en_ff <= wdata_ff[7:0];
            if (wr_reg == REG_MASK) mask_ff <= NUM_EVT'(merge(32'(mask_ff),
                                                 wdata_ff, wstrb_ff));
        end
    end

    // ---------------- Edge detection ----------------
    pic_edge_det u_nmi_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .sig(nmi_in),
        .rise_en(intctl_ff[NONMASKABLE_EDGE_BIT]), // [RQ6]
        .fall_en(~intctl_ff[NONMASKABLE_EDGE_BIT]), // [RQ6]
        .pulse(nmi_pulse)
    );

    pic_edge_det u_trig_a_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .sig(conv_trigger_a_input),
        .rise_en(intctl_ff[TRIG_A_EDGE_BIT]), // [RQ10]
        .fall_en(~intctl_ff[TRIG_A_EDGE_BIT]), // [RQ10]
        .pulse(trig_a_pulse)
    );

    pic_edge_det u_trig_b_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .sig(conv_trigger_b_input),
        .rise_en(intctl_ff[TRIG_B_EDGE_BIT]), // [RQ9]
        .fall_en(~intctl_ff[TRIG_B_EDGE_BIT]), // [RQ9]
        .pulse(trig_b_pulse)
    );

    // Sense code 00 falling, 01 rising, 10 or 11 both edges
    for (genvar k = 0; k < NUM_EXT; k++) begin : g_ext
        pic_edge_det u_irq_edge (
            .aclk(aclk),
            .aresetn(aresetn),
            .sig(ext_maskable_inputs[k]),
            .rise_en(sense_ff[2*k +: 2] != SENSE_FALL), // [RQ7]
            .fall_en(sense_ff[2*k +: 2] != SENSE_RISE), // [RQ7]
            .pulse(irq_pulse[k])
        );
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_start_a_ff <= 1'b0;
            conv_start_b_ff <= 1'b0;
        end else begin
            conv_start_a_ff <= trig_a_pulse; // [RQ10]
            conv_start_b_ff <= trig_b_pulse; // [RQ9]
        end
    end

    // ---------------- Status and summary interrupt ----------------
    assign evt = {trig_b_pulse, trig_a_pulse, irq_pulse, nmi_pulse};

    // A new event in the clearing cycle survives the write of one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= EVT_RST;
        end else if (wr_fire && wr_reg == REG_STATUS) begin
            status_ff <= (status_ff & ~wr_val[NUM_EVT-1:0]) | evt;
        end else begin
            status_ff <= status_ff | evt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) irq_out_ff <= 1'b0;
        else irq_out_ff <= |(status_ff & mask_ff);
    end

    // ---------------- Pending requests ----------------
    assign ack_clr = (cpu_ack ? cpu_clr_ff : '0) | (dtc_ack ? dtc_clr_ff : '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_pend_ff <= 1'b0;
            irq_pend_ff <= '0;
        end else begin
            nmi_pend_ff <= (nmi_pend_ff & ~ack_clr[0]) | nmi_pulse; // [RQ6]
            irq_pend_ff <= (irq_pend_ff & ~ack_clr[NUM_EXT:1]) |
                           irq_pulse; // [RQ7]
        end
    end

    // ---------------- Arbitration ----------------
    assign irq_live = irq_pend_ff & ~ack_clr[NUM_EXT:1];
    assign cpu_pend = {periph_req, irq_live & ~dtc_en_ff}; // [RQ8]
    assign mask_lvl = {cpu_mask_level_hi, cpu_mask_level_lo};
    assign mode2 = intctl_ff[MODE_LSB +: 2] == MODE_2; // [RQ1] [RQ2]

    // Source s uses field s mod 4 of priority register s div 4
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_lvl
        assign src_lvl[s] = prio_ff[s/4][7-2*(s%4) -: 2]; // [RQ13] [RQ3]
    end

    // Highest level wins; ties go to the lowest source index
    always_comb begin
        best_valid = 1'b0;
        best_lvl = '0;
        best_src = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (cpu_pend[s] &&
                (mode2 ? (src_lvl[s] > mask_lvl) : !cpu_mask_bit) && // [RQ14]
                (!best_valid || src_lvl[s] > best_lvl)) begin
                best_valid = 1'b1;
                best_lvl = src_lvl[s];
                best_src = 6'(s);
            end
        end
    end

    // Transfer requests bypass the CPU mask; lowest index first
    always_comb begin
        dtc_valid = 1'b0;
        dtc_src = '0;
        for (int k = NUM_EXT - 1; k >= 0; k--) begin
            if (irq_live[k] && dtc_en_ff[k]) begin
                dtc_valid = 1'b1;
                dtc_src = 3'(k);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_req_ff <= 1'b0;
            cpu_vec_ff <= '0;
            cpu_clr_ff <= '0;
        end else if (nmi_pend_ff && !ack_clr[0]) begin
            cpu_req_ff <= 1'b1; // [RQ4]
            cpu_vec_ff <= VEC_NMI;
            cpu_clr_ff <= 9'h001;
        end else if (flash_req) begin
            cpu_req_ff <= 1'b1; // [RQ4]
            cpu_vec_ff <= VEC_FLASH;
            cpu_clr_ff <= '0;
        end else if (best_valid) begin
            cpu_req_ff <= 1'b1; // [RQ2] [RQ14]
            cpu_vec_ff <= VEC_SRC_BASE + 8'(best_src); // [RQ5]
            cpu_clr_ff <= (best_src < 6'(NUM_EXT)) ?
                          9'(9'h002 << best_src) : '0;
        end else begin
            cpu_req_ff <= 1'b0;
            cpu_vec_ff <= '0;
            cpu_clr_ff <= '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dtc_req_ff <= 1'b0;
            dtc_vec_ff <= '0;
            dtc_clr_ff <= '0;
        end else begin
            dtc_req_ff <= dtc_valid; // [RQ8]
            dtc_vec_ff <= dtc_valid ? VEC_SRC_BASE + 8'(dtc_src) : '0;
            dtc_clr_ff <= dtc_valid ? 9'(9'h002 << dtc_src) : '0;
        end
    end

    // ---------------- Outputs ----------------
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign cpu_req = cpu_req_ff;
    assign cpu_vec_addr = {6'h00, cpu_vec_ff, 2'h0};
    assign dtc_req = dtc_req_ff;
    assign dtc_vec_num = dtc_vec_ff;
    assign conv_start_a = conv_start_a_ff;
    assign conv_start_b = conv_start_b_ff;
    assign irq_out = irq_out_ff;

    // ---------------- Assertions ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_prio0;
        wr_fire && wr_reg == REG_PRIO && wr_slot == 4'h0 && wstrb_ff[0];
    endsequence

    sequence s_rd_intctl;
        arvalid && arready_ff && rd_reg == REG_INTCTL;
    endsequence

    AST_MODE0_MASKED: assert property ( // [RQ1]
        (intctl_ff[MODE_LSB +: 2] == MODE_0 && cpu_mask_bit &&
         !nmi_pend_ff && !flash_req && !dtc_valid) |=> !cpu_req_ff
    ) else $error("mode 0 request passed the mask bit");

    AST_MODE2_LEVEL: assert property ( // [RQ2]
        (mode2 && !nmi_pend_ff && !flash_req && best_valid) |=>
        cpu_req_ff && cpu_vec_ff == VEC_SRC_BASE + 8'($past(best_src))
    ) else $error("mode 2 winner not forwarded");

    AST_ABOVE_MASK: assert property ( // [RQ14]
        (mode2 && best_valid) |-> best_lvl > mask_lvl
    ) else $error("level not above mask was chosen");

    AST_NMI_TOP: assert property ( // [RQ4]
        (nmi_pend_ff && !ack_clr[0]) |=>
        cpu_req_ff && cpu_vec_ff == VEC_NMI
    ) else $error("nonmaskable request not forwarded");

    AST_NMI_EDGE: assert property ( // [RQ6]
        (!intctl_ff[NONMASKABLE_EDGE_BIT] && $fell(nmi_in) &&
         $past(aresetn)) |=> nmi_pend_ff ##1 cpu_req_ff
    ) else $error("falling nonmaskable edge lost");

    AST_IRQ_EDGE: assert property ( // [RQ7]
        (irq_pulse != '0) |=>
        (irq_pend_ff & $past(irq_pulse)) == $past(irq_pulse)
    ) else $error("external edge did not set pending");

    AST_DTC_ROUTE: assert property ( // [RQ8]
        dtc_valid |=> dtc_req_ff && dtc_vec_ff == VEC_SRC_BASE +
                      8'($past(dtc_src))
    ) else $error("transfer request not raised");

    AST_TRIG_B: assert property ( // [RQ9]
        (intctl_ff[TRIG_B_EDGE_BIT] && $rose(conv_trigger_b_input) &&
         $past(aresetn)) |=> conv_start_b_ff ##1 !conv_start_b_ff
    ) else $error("trigger B rising edge missed");

    AST_TRIG_A: assert property ( // [RQ10]
        (!intctl_ff[TRIG_A_EDGE_BIT] && $fell(conv_trigger_a_input) &&
         $past(aresetn)) |=> conv_start_a_ff
    ) else $error("trigger A falling edge missed");

    AST_RSVD_ZERO: assert property ( // [RQ11]
        s_rd_intctl |=> rvalid_ff && rdata_ff[31:6] == '0 && !rdata_ff[0]
    ) else $error("reserved control bits not zero");

    AST_PRIO_WRITE: assert property ( // [RQ3]
        s_wr_prio0 |=> prio_ff[0] == $past(wdata_ff[7:0]) && bvalid_ff
    ) else $error("priority write not stored");

endmodule

// ==== pic_edge_det.sv ====
// Selectable edge detector for one synchronous input
module pic_edge_det
    import pic_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Input and edge selection
    input wire logic sig,
    input wire logic rise_en,
    input wire logic fall_en,
    // Detected edge
    output logic pulse
);

    logic prev_ff;
    logic armed_ff;

    // Arming keeps the level present at reset release from faking an edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else begin
            prev_ff <= sig;
            armed_ff <= 1'b1;
        end
    end

    assign pulse = armed_ff & ((rise_en & sig & ~prev_ff) |
                               (fall_en & ~sig & prev_ff));

endmodule

// ==== pic_pkg.sv ====
// Package of constants, register map and types for the interrupt controller
package pic_pkg;

    // Source counts
    localparam int NUM_EXT = 8;
    localparam int NUM_PERIPH = 28;
    localparam int NUM_SRC = 36;
    localparam int NUM_PRIO = 9;
    localparam int NUM_EVT = 11;

    // Register word indices; byte address is four times the index
    localparam logic [29:0] IDX_INTCTL = 30'h0ff0520;
    localparam logic [29:0] IDX_PRIO_A = 30'h0ff0529;
    localparam logic [29:0] IDX_PRIO_I = 30'h0ff0531;
    localparam logic [29:0] IDX_SENSE = 30'h0ff0540;
    localparam logic [29:0] IDX_DTC_EN = 30'h0ff0541;
    localparam logic [29:0] IDX_STATUS = 30'h0ff0542;
    localparam logic [29:0] IDX_MASK = 30'h0ff0543;

    // Control register fields
    localparam int MODE_LSB = 4;
    localparam int NONMASKABLE_EDGE_BIT = 3;
    localparam int TRIG_B_EDGE_BIT = 2;
    localparam int TRIG_A_EDGE_BIT = 1;
    localparam logic [7:0] INTCTL_RW_MASK = 8'h3e;
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_2 = 2'h2;

    // Reset values
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [7:0] PRIO_RST = 8'hff;
    localparam logic [15:0] SENSE_RST = 16'h0000;
    localparam logic [7:0] DTC_EN_RST = 8'h00;
    localparam logic [10:0] EVT_RST = 11'h000;

    // Per-input sense codes
    localparam logic [1:0] SENSE_FALL = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;

    // Event bit positions in status and mask
    localparam int EVT_NMI = 0;
    localparam int EVT_IRQ_LSB = 1;
    localparam int EVT_TRIG_A = 9;
    localparam int EVT_TRIG_B = 10;

    // Vector numbers
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [7:0] VEC_FLASH = 8'h0e;
    localparam logic [7:0] VEC_SRC_BASE = 8'h40;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        REG_NONE, REG_INTCTL, REG_PRIO, REG_SENSE, REG_DTC, REG_STATUS,
        REG_MASK
    } pic_reg_t;

    function automatic pic_reg_t pic_decode(input logic [29:0] idx);
        if (idx == IDX_INTCTL) return REG_INTCTL;
        if (idx >= IDX_PRIO_A && idx <= IDX_PRIO_I) return REG_PRIO;
        if (idx == IDX_SENSE) return REG_SENSE;
        if (idx == IDX_DTC_EN) return REG_DTC;
        if (idx == IDX_STATUS) return REG_STATUS;
        if (idx == IDX_MASK) return REG_MASK;
        return REG_NONE;
    endfunction

endpackage

// ==== tb_priority_interrupt_controller.sv ====
// Self-checking bench for the priority interrupt controller
module tb_priority_interrupt_controller
    import pic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [3:0] wstrb = 4'hf, lag = 4'h0;
    logic bready = 1'b1, rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic nmi_in = 1'b1, flash_req = 1'b0;
    logic [7:0] ext_maskable_inputs = 8'hff;
    logic [27:0] periph_req = 28'h0;
    logic conv_trigger_a_input = 1'b0, conv_trigger_b_input = 1'b0;
    logic cpu_mask_bit = 1'b0, cpu_mask_level_hi = 1'b0;
    logic cpu_mask_level_lo = 1'b0;
    logic cpu_req, cpu_ack, dtc_req, dtc_ack, irq_out;
    logic conv_start_a, conv_start_b;
    logic [15:0] cpu_vec_addr, cpu_last;
    logic [7:0] dtc_vec_num, dtc_last, cpu_cnt, dtc_cnt;
    int errors = 0, compares = 0, na = 0, nb = 0;

    pic_ctrl DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .nmi_in,
        .ext_maskable_inputs, .flash_req, .periph_req, .conv_trigger_a_input,
        .conv_trigger_b_input, .cpu_mask_bit, .cpu_mask_level_hi,
        .cpu_mask_level_lo, .cpu_req, .cpu_vec_addr, .cpu_ack, .dtc_req,
        .dtc_vec_num, .dtc_ack, .conv_start_a, .conv_start_b, .irq_out);
    pic_cpu_model cpu (.aclk, .aresetn, .lag, .cpu_req, .cpu_vec_addr,
        .cpu_ack, .cpu_cnt, .cpu_last, .dtc_req, .dtc_vec_num, .dtc_ack,
        .dtc_cnt, .dtc_last);

    initial forever #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        na += (conv_start_a === 1'b1);
        nb += (conv_start_b === 1'b1);
    end

    task automatic finish_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Address and data are each released at their own take edge
    task automatic wr(input logic [29:0] i, input logic [31:0] v);
        logic aw;
        logic w;
        awaddr <= {i, 2'h0};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw | w) begin
            @(posedge aclk);
            aw = aw & !awready;
            w = w & !wready;
            awvalid <= aw;
            wvalid <= w;
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
    endtask
    task automatic rd(input logic [29:0] i);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask
    task automatic exp_req(input logic data_transfer_controller, input logic [15:0] v);
        logic [7:0] c0;
        int n;
        c0 = data_transfer_controller ? dtc_cnt : cpu_cnt;
        n = 0;
        while ((data_transfer_controller ? dtc_cnt : cpu_cnt) == c0 && n < 40) begin
            @(posedge aclk);
            n++;
        end
        chk("acks", 32'(data_transfer_controller ? dtc_cnt : cpu_cnt), 32'(c0 + 8'h01));
        chk("vector", data_transfer_controller ? {24'h0, dtc_last} : {16'h0, cpu_last}, 32'(v));
    endtask
    task automatic exp_none;
        logic [7:0] c0;
        c0 = cpu_cnt;
        repeat (20) @(posedge aclk);
        chk("no request", 32'(cpu_cnt), 32'(c0));
    endtask

    task automatic t_regs;
        rd(IDX_INTCTL);
        chk("control", d, 32'h0);
        for (int i = 0; i < NUM_PRIO; i++) begin
            rd(IDX_PRIO_A + 30'(i));
            chk("priority", d, 32'hff);
        end
        wr(IDX_INTCTL, 32'hff);
        rd(IDX_INTCTL);
        chk("control", d, 32'h3e);
        wr(IDX_INTCTL + 30'h1, 32'h1);
        chk("bresp", 32'(r), 32'h2);
        rd(IDX_INTCTL + 30'h1);
        chk("rresp", {d[29:0], r}, 32'h2);
        wr(IDX_INTCTL, 32'h0);
    endtask
    task automatic t_ext;
        cpu_mask_bit <= 1'b1;
        ext_maskable_inputs[2] <= 1'b0;
        exp_none;
        cpu_mask_bit <= 1'b0;
        exp_req(1'b0, 16'h108);
        wr(IDX_SENSE, 32'h48);
        ext_maskable_inputs <= 8'hf5;
        exp_req(1'b0, 16'h104);
        ext_maskable_inputs <= 8'hf7;
        exp_req(1'b0, 16'h104);
        ext_maskable_inputs <= 8'hff;
        exp_req(1'b0, 16'h10c);
        ext_maskable_inputs <= 8'hf7;
        exp_none;
    endtask
    // Status sets while masked, then the mask and a W1C steer irq_out
    task automatic t_nmi;
        cpu_mask_bit <= 1'b1;
        nmi_in <= 1'b0;
        exp_req(1'b0, 16'h1c);
        chk("irq masked", 32'(irq_out), 32'h0);
        wr(IDX_MASK, 32'h1);
        @(posedge aclk);
        chk("irq", 32'(irq_out), 32'h1);
        wr(IDX_STATUS, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'(irq_out), 32'h0);
        wr(IDX_INTCTL, 32'h08);
        nmi_in <= 1'b1;
        exp_req(1'b0, 16'h1c);
        nmi_in <= 1'b0;
        exp_none;
    endtask
    task automatic t_mode2;
        wr(IDX_INTCTL, 32'h20);
        wr(IDX_PRIO_A, 32'h7f);
        cpu_mask_level_lo <= 1'b1;
        lag <= 4'h5;
        ext_maskable_inputs[0] <= 1'b0;
        exp_none;
        cpu_mask_level_lo <= 1'b0;
        exp_req(1'b0, 16'h100);
        cpu_mask_level_hi <= 1'b1;
        cpu_mask_level_lo <= 1'b1;
        flash_req <= 1'b1;
        exp_req(1'b0, 16'h38);
        flash_req <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask
    task automatic t_dtc;
        wr(IDX_INTCTL, 32'h0);
        wr(IDX_DTC_EN, 32'h1);
        lag <= 4'h0;
        ext_maskable_inputs[0] <= 1'b1;
        @(posedge aclk);
        ext_maskable_inputs[0] <= 1'b0;
        exp_req(1'b1, 16'h40);
    endtask
    task automatic t_trig;
        for (int m = 0; m < 2; m++) begin
            wr(IDX_INTCTL, m ? 32'h02 : 32'h00);
            conv_trigger_a_input <= 1'b1;
            conv_trigger_b_input <= 1'b1;
            repeat (4) @(posedge aclk);
            chk("start a", na, 2 * m);
            chk("start b", nb, m);
            conv_trigger_a_input <= 1'b0;
            conv_trigger_b_input <= 1'b0;
            repeat (4) @(posedge aclk);
            chk("start a", na, 1 + m);
            chk("start b", nb, 1 + m);
        end
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs;
        t_ext;
        t_nmi;
        t_mode2;
        t_dtc;
        t_trig;
        finish_test;
    end
    // The sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        finish_test;
    end
endmodule
